// >>> rtl/prog_pkg.sv
`default_nettype none
package prog_pkg;
  // Clock rate and self-timed write times
  localparam int CLK_MHZ = 50;
  localparam int PROG_WAIT_US = 4000;
  localparam int ERASE_WAIT_US = 8000;
  localparam int PROG_WAIT_CYC = PROG_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int BUSY_CNT_W = 24;
  // Memory sizes
  localparam int FLASH_WORDS = 1024;
  localparam int EEP_BYTES = 128;
  // Frame lengths in bits, and the low-voltage bit where read data starts
  localparam logic [5:0] LV_FRAME_BITS = 6'h20;
  localparam logic [5:0] LV_READ_BIT = 6'h18;
  localparam logic [5:0] HV_FRAME_BITS = 6'h0B;
  // Low-voltage instruction codes
  localparam logic [7:0] LV_ENABLE_B1 = 8'hAC;
  localparam logic [7:0] LV_ENABLE_B2 = 8'h53;
  localparam logic [2:0] LV_ERASE_TOP = 3'h4;
  localparam logic [4:0] LV_LOCK_TOP = 5'h1F;
  localparam logic [6:0] LV_FUSE_TOP = 7'h5F;
  localparam logic [3:0] LV_RD_FLASH = 4'h2;
  localparam logic [3:0] LV_WR_FLASH = 4'h4;
  localparam logic [7:0] LV_RD_EEP = 8'hA0;
  localparam logic [7:0] LV_WR_EEP = 8'hC0;
  localparam logic [7:0] LV_RD_FUSE = 8'h58;
  localparam logic [7:0] LV_RD_SIG = 8'h30;
  // High-voltage frame kinds (instruction pin byte)
  localparam logic [7:0] HV_LOAD_CMD = 8'h4C;
  localparam logic [7:0] HV_LOAD_ADDR_LO = 8'h0C;
  localparam logic [7:0] HV_LOAD_ADDR_HI = 8'h1C;
  localparam logic [7:0] HV_LOAD_DATA_LO = 8'h2C;
  localparam logic [7:0] HV_LOAD_DATA_HI = 8'h3C;
  // High-voltage commands (data pin byte of a command frame)
  localparam logic [7:0] HV_CMD_FUSE = 8'h04;
  localparam logic [7:0] HV_CMD_SIG = 8'h08;
  localparam logic [7:0] HV_CMD_RD_FLASH_LO = 8'h02;
  localparam logic [7:0] HV_CMD_RD_FLASH_HI = 8'h03;
  localparam logic [7:0] HV_CMD_RD_EEP = 8'h05;
  localparam logic [7:0] HV_CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] HV_CMD_WR_EEP = 8'h11;
  localparam logic [7:0] HV_CMD_ERASE = 8'h80;
  // Reset values of lock and fuse bits (0 = programmed)
  localparam logic [1:0] LOCK_RST = 2'h3;
  localparam logic OSC_FUSE_RST = 1'b1;
  localparam logic SPI_FUSE_RST = 1'b0;
  // Signature bytes 3..0, value arbitrary
  localparam logic [31:0] SIG_DEFAULT = 32'h0003_0201;

  typedef enum logic [1:0] {
    WR_NONE = 2'b00,
    WR_FLASH = 2'b01,
    WR_EEP = 2'b10,
    WR_ERASE = 2'b11
  } write_kind_e;

  typedef struct packed {
    logic hv;
    logic last;
    logic [31:0] word;
  } link_evt_s;

  typedef struct packed {
    write_kind_e kind;
    logic [9:0] addr;
    logic [1:0] byteEn;
    logic [15:0] data;
  } pend_write_s;
endpackage
`default_nettype wire

// >>> rtl/sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  if (WIDTH < 1) begin : g_width_chk
    $error("Synchroniser width must be at least one");
  end

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule
`default_nettype wire

// >>> rtl/serial_program_interface.sv
`timescale 1ns/1ps
`default_nettype none
module serial_program_interface #(
  parameter int FLASH_WORDS = prog_pkg::FLASH_WORDS,
  parameter int EEP_BYTES = prog_pkg::EEP_BYTES,
  parameter int PROG_WAIT_CYCLES = prog_pkg::PROG_WAIT_CYC,
  parameter int ERASE_WAIT_CYCLES = prog_pkg::ERASE_WAIT_CYC,
  parameter logic [31:0] SIGNATURE = prog_pkg::SIG_DEFAULT
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Programming pins
  input wire logic serialClk,
  input wire logic resetPin,
  input wire logic hvLevel,
  input wire logic hvDataInPin,
  input wire logic hvInstructionInPinIn,
  output logic hvInstructionInPinOut,
  output logic hvInstructionInPinOe,
  output logic hvDataOutPinOut,
  output logic hvDataOutPinOe,
  // Status
  output logic readyBusyIndicator,
  output logic progEnabled,
  output logic [1:0] lockBits,
  output logic internalOscillatorFuse,
  output logic serialProgrammingEnableFuse
);
  import prog_pkg::*;

  if (FLASH_WORDS < 1 || FLASH_WORDS > 1024 || EEP_BYTES < 1 ||
      EEP_BYTES > 128) begin : g_size_chk
    $error("Memory size outside the address fields");
  end
  if (PROG_WAIT_CYCLES < 1 || ERASE_WAIT_CYCLES < 1 ||
      PROG_WAIT_CYCLES >= 2**BUSY_CNT_W ||
      ERASE_WAIT_CYCLES >= 2**BUSY_CNT_W) begin : g_time_chk
    $error("Write time does not fit the busy counter");
  end

  // Link domain
  logic linkClr;
  logic [5:0] bitCnt_r;
  logic [31:0] lvShift_r;
  logic [9:0] hvDataSh_r;
  logic [9:0] hvInstSh_r;
  link_evt_s evt_r;
  logic evtToggle_r;
  logic hvOut_r;
  logic [9:0] hvOutSh_r;
  logic miso_r;
  logic [6:0] rdSh_r;
  // Core domain
  logic [10:0] resp_r;
  logic evtTogS, rstPinS, hvModeS, evtTogPrev_r, evtSeen;
  logic lvExec, lvPrep, hvFrame, hvPend_r, enabled_r, busy, startWr;
  logic [7:0] b1, b2, b3, b4, ib, db, lvRead, sigByte;
  logic [7:0] hvCmd_r, hvAddrLo_r, hvAddrHi_r, hvDataLo_r;
  logic [10:0] hvResp;
  logic [1:0] lockBits_r;
  logic oscFuse_r, spiFuse_r;
  write_kind_e wrState_r;
  logic [BUSY_CNT_W-1:0] busyCnt_r;
  pend_write_s pend_r, req;
  logic [15:0] flashMem [FLASH_WORDS];
  logic [7:0] eepMem [EEP_BYTES];

  // Reset pin high outside high-voltage mode drops frame alignment
  assign linkClr = resetPin & ~hvLevel;

  always_ff @(posedge serialClk or posedge linkClr) begin
    if (linkClr) begin
      bitCnt_r <= 6'h00;
      lvShift_r <= 32'h0000_0000;
      hvDataSh_r <= 10'h000;
      hvInstSh_r <= 10'h000;
      evt_r <= '0;
      evtToggle_r <= 1'b0;
    end else if (hvLevel) begin
      hvDataSh_r <= {hvDataSh_r[8:0], hvDataInPin};
      hvInstSh_r <= {hvInstSh_r[8:0], hvInstructionInPinIn};
      if (bitCnt_r == HV_FRAME_BITS - 6'h01) begin
        bitCnt_r <= 6'h00;
        evt_r <= '{hv: 1'b1, last: 1'b1,
                   word: {16'h0000, hvDataSh_r[8:1], hvInstSh_r[8:1]}};
        evtToggle_r <= ~evtToggle_r;
      end else begin
        bitCnt_r <= bitCnt_r + 6'h01;
      end
    end else begin
      lvShift_r <= {lvShift_r[30:0], hvDataInPin};
      if (bitCnt_r == LV_FRAME_BITS - 6'h01) begin
        bitCnt_r <= 6'h00;
        evt_r <= '{hv: 1'b0, last: 1'b1,
                   word: {lvShift_r[30:0], hvDataInPin}};
        evtToggle_r <= ~evtToggle_r;
      end else begin
        bitCnt_r <= bitCnt_r + 6'h01;
        if (bitCnt_r == LV_READ_BIT - 6'h01) begin
          evt_r <= '{hv: 1'b0, last: 1'b0,
                     word: {lvShift_r[22:0], hvDataInPin, 8'h00}};
          evtToggle_r <= ~evtToggle_r;
        end
      end
    end
  end

  // High-voltage output frame: start bit first, loaded at frame start
  always_ff @(posedge serialClk or posedge linkClr) begin
    if (linkClr) begin
      hvOut_r <= 1'b1;
      hvOutSh_r <= 10'h000;
    end else if (bitCnt_r == 6'h00) begin
      {hvOut_r, hvOutSh_r} <= resp_r;
    end else begin
      {hvOut_r, hvOutSh_r} <= {hvOutSh_r, 1'b0};
    end
  end

  // Low-voltage output changes on the falling edge
  always_ff @(negedge serialClk or posedge linkClr) begin
    if (linkClr) begin
      miso_r <= 1'b0;
      rdSh_r <= 7'h00;
    end else if (bitCnt_r == LV_READ_BIT) begin
      miso_r <= resp_r[9];
      rdSh_r <= resp_r[8:2];
    end else if (bitCnt_r > LV_READ_BIT) begin
      miso_r <= rdSh_r[6];
      rdSh_r <= {rdSh_r[5:0], 1'b0};
    end else begin
      miso_r <= lvShift_r[7];
    end
  end

  sync_2ff #(.WIDTH(3)) u_sync_2ff (
    .clk(clk),
    .srst(srst),
    .din({evtToggle_r, resetPin, hvLevel}),
    .dout({evtTogS, rstPinS, hvModeS})
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      evtTogPrev_r <= 1'b0;
      hvPend_r <= 1'b0;
    end else begin
      evtTogPrev_r <= evtTogS;
      hvPend_r <= hvFrame;
    end
  end

  // Event word is held stable for many core cycles after its toggle
  assign evtSeen = evtTogS ^ evtTogPrev_r;
  assign b1 = evt_r.word[31:24];
  assign b2 = evt_r.word[23:16];
  assign b3 = evt_r.word[15:8];
  assign b4 = evt_r.word[7:0];
  assign db = evt_r.word[15:8];
  assign ib = evt_r.word[7:0];
  assign lvExec = evtSeen & ~evt_r.hv & evt_r.last;
  assign lvPrep = evtSeen & ~evt_r.hv & ~evt_r.last;
  assign hvFrame = evtSeen & evt_r.hv;
  assign busy = wrState_r != WR_NONE;

  always_ff @(posedge clk) begin
    if (srst || (rstPinS && !hvModeS)) begin
      enabled_r <= 1'b0;
    end else if (lvExec && !rstPinS && b1 == LV_ENABLE_B1 &&
                 b2 == LV_ENABLE_B2 && !spiFuse_r) begin
      enabled_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hvCmd_r <= 8'h00;
      hvAddrLo_r <= 8'h00;
      hvAddrHi_r <= 8'h00;
      hvDataLo_r <= 8'h00;
    end else if (hvFrame) begin
      if (ib == HV_LOAD_CMD) hvCmd_r <= db;
      if (ib == HV_LOAD_ADDR_LO) hvAddrLo_r <= db;
      if (ib == HV_LOAD_ADDR_HI) hvAddrHi_r <= db;
      if (ib == HV_LOAD_DATA_LO) hvDataLo_r <= db;
    end
  end

  always_comb begin
    req.kind = WR_NONE;
    req.addr = 10'h000;
    req.byteEn = 2'b00;
    req.data = 16'h0000;
    if (lvExec && enabled_r) begin
      if (b1 == LV_ENABLE_B1 && b2[7:5] == LV_ERASE_TOP) begin
        req.kind = WR_ERASE;
      end else if (b1[7:4] == LV_WR_FLASH && b1[2:0] == 3'h0) begin
        req.kind = WR_FLASH;
        req.addr = {b2[1:0], b3};
        req.byteEn = b1[3] ? 2'b10 : 2'b01;
        req.data = {b4, b4};
      end else if (b1 == LV_WR_EEP) begin
        req.kind = WR_EEP;
        req.addr = {3'h0, b3[6:0]};
        req.data = {8'h00, b4};
      end
    end else if (hvFrame) begin
      if (ib == HV_LOAD_CMD && db == HV_CMD_ERASE) begin
        req.kind = WR_ERASE;
      end else if (ib == HV_LOAD_DATA_HI && hvCmd_r == HV_CMD_WR_FLASH) begin
        req.kind = WR_FLASH;
        req.addr = {hvAddrHi_r[1:0], hvAddrLo_r};
        req.byteEn = 2'b11;
        req.data = {db, hvDataLo_r};
      end else if (ib == HV_LOAD_DATA_LO && hvCmd_r == HV_CMD_WR_EEP) begin
        req.kind = WR_EEP;
        req.addr = {3'h0, hvAddrLo_r[6:0]};
        req.data = {8'h00, db};
      end
    end
  end

  assign startWr = (req.kind != WR_NONE) && !busy;

  always_ff @(posedge clk) begin
    if (srst) begin
      wrState_r <= WR_NONE;
      busyCnt_r <= '0;
      pend_r <= '0;
    end else begin
      unique case (wrState_r)
        WR_NONE: begin
          if (startWr) begin
            pend_r <= req;
            wrState_r <= req.kind;
            busyCnt_r <= (req.kind == WR_ERASE) ?
                         BUSY_CNT_W'(ERASE_WAIT_CYCLES - 1) :
                         BUSY_CNT_W'(PROG_WAIT_CYCLES - 1);
          end
        end
        WR_FLASH, WR_EEP, WR_ERASE: begin
          if (busyCnt_r == '0) wrState_r <= WR_NONE;
          else busyCnt_r <= busyCnt_r - BUSY_CNT_W'(1);
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (wrState_r == WR_ERASE && busyCnt_r == '0) begin
      for (int i = 0; i < FLASH_WORDS; i++) flashMem[i] <= 16'hFFFF;
      for (int i = 0; i < EEP_BYTES; i++) eepMem[i] <= 8'hFF;
    end else begin
      if (startWr && req.kind == WR_EEP && req.addr < EEP_BYTES)
        eepMem[req.addr[6:0]] <= 8'hFF;
      if (wrState_r == WR_EEP && busyCnt_r == '0 &&
          pend_r.addr < EEP_BYTES)
        eepMem[pend_r.addr[6:0]] <= pend_r.data[7:0];
      if (wrState_r == WR_FLASH && busyCnt_r == '0 &&
          pend_r.addr < FLASH_WORDS) begin
        if (pend_r.byteEn[0])
          flashMem[pend_r.addr][7:0] <=
            flashMem[pend_r.addr][7:0] & pend_r.data[7:0];
        if (pend_r.byteEn[1])
          flashMem[pend_r.addr][15:8] <=
            flashMem[pend_r.addr][15:8] & pend_r.data[15:8];
      end
    end
  end

  // Locks return to unprogrammed only through chip erase or srst
  always_ff @(posedge clk) begin
    if (srst) begin
      lockBits_r <= LOCK_RST;
      oscFuse_r <= OSC_FUSE_RST;
      spiFuse_r <= SPI_FUSE_RST;
    end else if (wrState_r == WR_ERASE && busyCnt_r == '0) begin
      lockBits_r <= LOCK_RST;
    end else if (lvExec && enabled_r && b1 == LV_ENABLE_B1) begin
      if (b2[7:3] == LV_LOCK_TOP)
        lockBits_r <= lockBits_r & {b2[2], b2[1]};
      if (b2[7:1] == LV_FUSE_TOP)
        oscFuse_r <= b2[0];
    end
  end

  always_comb begin
    sigByte = SIGNATURE[{hvFrame ? hvAddrLo_r[1:0] : b3[1:0], 3'h0} +: 8];
    if (hvPend_r) sigByte = SIGNATURE[{hvAddrLo_r[1:0], 3'h0} +: 8];
    if (lockBits_r == 2'b00) sigByte = 8'h00;
  end

  always_comb begin
    lvRead = 8'h00;
    if (!enabled_r) begin
      lvRead = 8'h00;
    end else if (b1[7:4] == LV_RD_FLASH && b1[2:0] == 3'h0) begin
      lvRead = 8'hFF;
      if ({b2[1:0], b3} < FLASH_WORDS)
        lvRead = b1[3] ? flashMem[{b2[1:0], b3}][15:8] :
                         flashMem[{b2[1:0], b3}][7:0];
    end else if (b1 == LV_RD_EEP) begin
      lvRead = (b3[6:0] < EEP_BYTES) ? eepMem[b3[6:0]] : 8'hFF;
    end else if (b1 == LV_RD_FUSE) begin
      lvRead = {lockBits_r[0], lockBits_r[1], spiFuse_r, 4'h0, oscFuse_r};
    end else if (b1 == LV_RD_SIG) begin
      lvRead = sigByte;
    end
  end

  always_comb begin
    hvResp = 11'h000;
    unique case (hvCmd_r)
      HV_CMD_SIG: hvResp = {1'b0, sigByte, 2'b00};
      HV_CMD_FUSE: hvResp = {lockBits_r[0], lockBits_r[1], spiFuse_r,
                             4'h0, oscFuse_r, 3'h0};
      HV_CMD_RD_FLASH_LO, HV_CMD_RD_FLASH_HI: begin
        if ({hvAddrHi_r[1:0], hvAddrLo_r} < FLASH_WORDS)
          hvResp = {1'b0, hvCmd_r[0] ?
                    flashMem[{hvAddrHi_r[1:0], hvAddrLo_r}][15:8] :
                    flashMem[{hvAddrHi_r[1:0], hvAddrLo_r}][7:0], 2'b00};
      end
      HV_CMD_RD_EEP: begin
        if (hvAddrLo_r[6:0] < EEP_BYTES)
          hvResp = {1'b0, eepMem[hvAddrLo_r[6:0]], 2'b00};
      end
      default: hvResp = 11'h000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) resp_r <= 11'h000;
    else if (lvPrep) resp_r <= {1'b0, lvRead, 2'b00};
    else if (hvPend_r) resp_r <= hvResp;
  end

  assign hvInstructionInPinOut = miso_r;
  assign hvInstructionInPinOe = ~hvModeS & ~rstPinS;
  assign hvDataOutPinOut = hvOut_r & ~busy;
  assign hvDataOutPinOe = hvModeS;
  assign readyBusyIndicator = ~busy;
  assign progEnabled = enabled_r;
  assign lockBits = lockBits_r;
  assign internalOscillatorFuse = oscFuse_r;
  assign serialProgrammingEnableFuse = spiFuse_r;

  // Checks
  int busyLen_r;
  always_ff @(posedge clk) begin
    if (srst || !busy) busyLen_r <= 0;
    else busyLen_r <= busyLen_r + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_busy_after_write: assert property (
    startWr |=> busy && !readyBusyIndicator && !hvDataOutPinOut)
    else $error("Write did not raise busy");
  a_eep_erase_first: assert property (
    startWr && req.kind == WR_EEP |=> eepMem[pend_r.addr[6:0]] == 8'hFF)
    else $error("EEPROM cell not erased before write");
  a_erase_all_ones: assert property (
    wrState_r == WR_ERASE && busyCnt_r == '0 |=>
      flashMem[0] == 16'hFFFF && eepMem[EEP_BYTES-1] == 8'hFF)
    else $error("Chip erase left cells not at ones");
  a_busy_length: assert property (
    busy && busyCnt_r == '0 |-> busyLen_r ==
      ((wrState_r == WR_ERASE) ? ERASE_WAIT_CYCLES : PROG_WAIT_CYCLES) - 1)
    else $error("Self-timed write has wrong length");
  a_enable_reset_low: assert property (
    $rose(enabled_r) |-> $past(lvExec) && !$past(rstPinS))
    else $error("Enable accepted without reset low");
  a_ignore_disabled: assert property (
    lvExec && !enabled_r && !busy |=> !busy)
    else $error("Instruction acted before enable");
  a_sig_hidden: assert property (
    lvPrep && enabled_r && b1 == LV_RD_SIG && lockBits_r == 2'b00 |=>
      resp_r == 11'h000)
    else $error("Signature shown in full lock mode");
  a_fuse_frame: assert property (
    hvPend_r && hvCmd_r == HV_CMD_FUSE |=> resp_r[8] == spiFuse_r &&
      resp_r[3] == oscFuse_r && resp_r[10] == lockBits_r[0])
    else $error("Fuse frame layout wrong");
  a_lock_sticky: assert property (
    $rose(lockBits_r[0]) || $rose(lockBits_r[1]) |->
      $past(wrState_r) == WR_ERASE)
    else $error("Lock bit released without erase");

  c_enable: cover property ($rose(enabled_r));
  c_eep_done: cover property (wrState_r == WR_EEP ##1 !busy);
  c_erase: cover property (startWr && req.kind == WR_ERASE);
  c_hv_sig: cover property (hvPend_r && hvCmd_r == HV_CMD_SIG);
endmodule
`default_nettype wire

// >>> bench/prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_model (
  // Pins toward the device
  output logic serialClk,
  output logic dataPin,
  output logic instrPin,
  output logic resetPin,
  output logic hvLevel,
  // Pins from the device
  input wire logic instrLine,
  input wire logic outLine
);
  localparam time PH = 110ns;
  initial begin
    serialClk = 1'b0;
    dataPin = 1'b0;
    instrPin = 1'b0;
    resetPin = 1'b1;
    hvLevel = 1'b0;
  end
  // Data moves only while the clock is low
  task automatic pulse(input logic d, input logic i, output logic lv,
                       output logic hv);
    dataPin = d;
    instrPin = i;
    #PH;
    lv = instrLine;
    serialClk = 1'b1;
    #(PH / 2);
    hv = outLine;
    #(PH / 2);
    serialClk = 1'b0;
  endtask
  // Reset pulse with the clock held low realigns framing
  task automatic lvStart();
    serialClk = 1'b0;
    hvLevel = 1'b0;
    resetPin = 1'b1;
    #1us;
    resetPin = 1'b0;
    #2us; // Shortened settle wait
  endtask
  task automatic lvInstr(input logic [31:0] w, output logic [7:0] echo,
                         output logic [7:0] rd);
    logic [31:0] s;
    logic hv;
    for (int i = 31; i >= 0; i--) begin
      pulse(w[i], 1'b0, s[i], hv);
    end
    dataPin = ~dataPin;
    echo = s[15:8];
    rd = s[7:0];
  endtask
  task automatic hvEnter();
    logic a;
    logic b;
    resetPin = 1'b0;
    hvLevel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pulse(1'b0, 1'b0, a, b);
    end
    #PH;
    // Reset ramps through its normal high level, which clears framing
    resetPin = 1'b1;
    #PH;
    hvLevel = 1'b1;
    #8us;
  endtask
  task automatic hvFrame(input logic [7:0] d, input logic [7:0] ins,
                         output logic [10:0] o);
    logic [10:0] dw;
    logic [10:0] iw;
    logic lv;
    dw = {1'b0, d, 2'b00};
    iw = {1'b0, ins, 2'b00};
    #200ns;
    for (int i = 10; i >= 0; i--) begin
      pulse(dw[i], iw[i], lv, o[i]);
    end
    dataPin = ~dataPin;
    instrPin = ~instrPin;
  endtask
endmodule
`default_nettype wire

// >>> bench/serial_program_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_program_interface_bench;
  import prog_pkg::*;
  localparam int PROG_CYC = 20;
  localparam int ERASE_CYC = 40;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic serialClk, dataPin, instrPin, resetPin, hvLevel, instrLine;
  logic misoOut, misoOe, hvOut, hvOe, ready, enabled, oscFuse, spiFuse;
  logic [1:0] locks;
  logic [7:0] echo, rd;
  logic [10:0] hvo;
  int nErrors = 0;
  int samplesChecked = 0;
  logic [31:0] erased [3] = '{32'hA000_7F00, 32'h2803_FF00, 32'h2000_0000};
  logic [31:0] wrW [4] = '{32'hC000_7F5A, 32'hC000_7FA5, 32'h4003_FF3C,
                           32'h4803_FFC3};
  logic [31:0] rdW [4] = '{32'hA000_7F00, 32'hA000_7F00, 32'h2003_FF00,
                           32'h2803_FF00};

  always #10 clk = ~clk;
  // Device owns the instruction pin in low-voltage mode while reset is low
  assign instrLine = misoOe ? misoOut : instrPin;

  serial_program_interface #(.PROG_WAIT_CYCLES(PROG_CYC),
    .ERASE_WAIT_CYCLES(ERASE_CYC)) u_serial_program_interface (
    .clk(clk), .srst(srst), .serialClk(serialClk), .resetPin(resetPin),
    .hvLevel(hvLevel), .hvDataInPin(dataPin),
    .hvInstructionInPinIn(instrLine), .hvInstructionInPinOut(misoOut),
    .hvInstructionInPinOe(misoOe), .hvDataOutPinOut(hvOut),
    .hvDataOutPinOe(hvOe), .readyBusyIndicator(ready),
    .progEnabled(enabled), .lockBits(locks),
    .internalOscillatorFuse(oscFuse), .serialProgrammingEnableFuse(spiFuse));

  prog_model u_prog_model (
    .serialClk(serialClk), .dataPin(dataPin), .instrPin(instrPin),
    .resetPin(resetPin), .hvLevel(hvLevel), .instrLine(instrLine),
    .outLine(hvOut));

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic lv(input logic [31:0] w);
    u_prog_model.lvInstr(w, echo, rd);
  endtask
  task automatic hv(input logic [7:0] d, input logic [7:0] ins);
    u_prog_model.hvFrame(d, ins, hvo);
  endtask
  task automatic hvAddr(input logic [7:0] cmd, input logic [7:0] a);
    hv(cmd, HV_LOAD_CMD);
    hv(a, HV_LOAD_ADDR_LO);
    hv(8'h00, HV_LOAD_ADDR_HI);
  endtask
  // Busy must start promptly and last the self-timed count
  task automatic waitBusy(input int cyc, input logic hvMode);
    int n;
    n = 0;
    while (ready !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("busyStart", ready, 1'b0);
    if (hvMode) chk("busyPin", hvOut, 1'b0);
    n = 0;
    while (ready !== 1'b1 && n < 2 * cyc) begin
      @(negedge clk);
      n++;
    end
    chk("busyLen", n >= cyc - 10 && n <= cyc + 2, 1'b1);
    if (n >= 2 * cyc) wrap_up();
  endtask

  initial begin
    #1ms;
    nErrors++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(negedge clk);
    chk("ready", ready, 1'b1);
    chk("locks", locks, 2'h3);
    chk("fuses", {spiFuse, oscFuse}, 2'h1);
    u_prog_model.lvStart();
    lv(32'hC000_05AA);
    repeat (30) @(negedge clk);
    chk("ignoredWrite", ready, 1'b1);
    lv(32'hA000_0500);
    chk("earlyRead", rd, 8'h00);
    chk("enableEarly", enabled, 1'b0);
    lv({LV_ENABLE_B1, LV_ENABLE_B2, 16'h0000});
    chk("echo", echo, LV_ENABLE_B2);
    repeat (5) @(negedge clk);
    chk("enabled", enabled, 1'b1);
    chk("lvOe", {misoOe, hvOe}, 2'h2);
    lv({LV_ENABLE_B1, 8'h80, 16'h0000});
    waitBusy(ERASE_CYC, 1'b0);
    u_prog_model.lvStart();
    chk("enableCleared", enabled, 1'b0);
    lv({LV_ENABLE_B1, LV_ENABLE_B2, 16'h0000});
    foreach (erased[i]) begin
      lv(erased[i]);
      chk("erased", rd, 8'hFF);
    end
    foreach (wrW[i]) begin
      lv(wrW[i]);
      waitBusy(PROG_CYC, 1'b0);
      lv(rdW[i]);
      chk("readBack", rd, wrW[i][7:0]);
      chk("echoAddr", echo, rdW[i][23:16]);
    end
    lv(32'h2003_FF00);
    chk("lowKept", rd, 8'h3C);
    lv(32'h3000_0100);
    chk("sigLv", rd, SIG_DEFAULT[15:8]);
    lv(32'h5800_0000);
    chk("fuseLv", rd, 8'hC1);
    u_prog_model.hvEnter();
    chk("hvOe", {misoOe, hvOe}, 2'h1);
    hv(HV_CMD_SIG, HV_LOAD_CMD);
    hv(8'h02, HV_LOAD_ADDR_LO);
    hv(8'h00, 8'h68);
    chk("sigA", hvo, {1'b0, SIG_DEFAULT[23:16], 2'b00});
    hv(8'h00, 8'h6C);
    chk("sigB", hvo, {1'b0, SIG_DEFAULT[23:16], 2'b00});
    hv(HV_CMD_FUSE, HV_LOAD_CMD);
    hv(8'h00, 8'h78);
    hv(8'h00, 8'h7C);
    chk("fuseHv", hvo, 11'h608);
    hvAddr(HV_CMD_WR_EEP, 8'h10);
    hv(8'h77, HV_LOAD_DATA_LO);
    waitBusy(PROG_CYC, 1'b1);
    hvAddr(HV_CMD_RD_EEP, 8'h10);
    hv(8'h00, 8'h68);
    chk("eepHv", hvo, {1'b0, 8'h77, 2'b00});
    hvAddr(HV_CMD_WR_FLASH, 8'h00);
    hv(8'h12, HV_LOAD_DATA_LO);
    hv(8'h34, HV_LOAD_DATA_HI);
    waitBusy(PROG_CYC, 1'b1);
    hvAddr(HV_CMD_RD_FLASH_HI, 8'h00);
    hv(8'h00, 8'h68);
    chk("flashHi", hvo, {1'b0, 8'h34, 2'b00});
    hvAddr(HV_CMD_RD_FLASH_LO, 8'h00);
    hv(8'h00, 8'h68);
    chk("flashLo", hvo, {1'b0, 8'h12, 2'b00});
    u_prog_model.lvStart();
    lv({LV_ENABLE_B1, LV_ENABLE_B2, 16'h0000});
    lv({LV_ENABLE_B1, 8'hF9, 16'h0000});
    repeat (60) @(negedge clk);
    chk("locked", locks, 2'h0);
    lv(32'h3000_0100);
    chk("sigHidden", rd, 8'h00);
    lv(32'h5800_0000);
    chk("fuseLocked", rd, 8'h01);
    lv({LV_ENABLE_B1, 8'hBE, 16'h0000});
    repeat (5) @(negedge clk);
    chk("oscFuse", oscFuse, 1'b0);
    lv(32'h5800_0000);
    chk("fuseWritten", rd, 8'h00);
    u_prog_model.hvEnter();
    hv(HV_CMD_ERASE, HV_LOAD_CMD);
    waitBusy(ERASE_CYC, 1'b1);
    chk("locksErased", locks, 2'h3);
    hvAddr(HV_CMD_RD_FLASH_HI, 8'h00);
    hv(8'h00, 8'h68);
    chk("flashErased", hvo, {1'b0, 8'hFF, 2'b00});
    wrap_up();
  end
endmodule
`default_nettype wire
